//--- verilog/tpw_timer.sv
// Purpose: Fast and phase correct PWM generator of an 8-bit timer, two channels.
// Assumes: Inputs synchronous to i_ref_clk; i_clk_en freezes all state.
// Notes:   Pins carry the internal compare state and an override enable.
`timescale 1ns/1ps
module tpw_timer
  import tpw_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Compare outputs
  output logic            o_wave_output_a,
  output logic            o_wave_output_b,
  output logic            o_override_a,
  output logic            o_override_b,
  // Flags
  output logic            o_overflow_flag,
  output logic            o_compare_flag_a,
  output logic            o_compare_flag_b
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] wgm;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] presc_sel;
    logic [9:0] presc_cnt;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] count;
    logic       down;
    logic       wave_a;
    logic       wave_b;
    logic       ovf;
    logic       flag_a;
    logic       flag_b;
    logic [7:0] rdata;
  } tpw_state_t;

  tpw_state_t st;
  tpw_state_t next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] tpw_div_limit(input logic [2:0] sel);
    case (sel)
      3'h1:    tpw_div_limit = 10'h000;
      3'h2:    tpw_div_limit = 10'h007;
      3'h3:    tpw_div_limit = 10'h01f;
      3'h4:    tpw_div_limit = 10'h03f;
      3'h5:    tpw_div_limit = 10'h07f;
      3'h6:    tpw_div_limit = 10'h0ff;
      3'h7:    tpw_div_limit = 10'h3ff;
      default: tpw_div_limit = PRESC_ZERO;
    endcase
  endfunction : tpw_div_limit

  function automatic logic tpw_is_fast(input logic [2:0] w);
    tpw_is_fast = (w == WGM_FAST_MAX) || (w == WGM_FAST_OCRA);
  endfunction : tpw_is_fast

  function automatic logic tpw_is_pc(input logic [2:0] w);
    tpw_is_pc = (w == WGM_PC_MAX) || (w == WGM_PC_OCRA);
  endfunction : tpw_is_pc

  // One channel's next level. Fast: at_wrap gives the BOTTOM level.
  // Phase correct: up/down match levels; at TOP the up-match level is
  // forced if the match was missed or skipped, keeping BOTTOM symmetric.
  function automatic logic tpw_wave(input logic       cur,
                                    input logic [1:0] com,
                                    input logic       fast,
                                    input logic       tog_ok,
                                    input logic       match,
                                    input logic       at_top,
                                    input logic       at_wrap,
                                    input logic       down,
                                    input logic       cmp_is_top);
    logic inv;
    inv      = (com == COM_INV);
    tpw_wave = cur;
    if (com == COM_TOGGLE) begin
      if (tog_ok && match) begin
        tpw_wave = ~cur;
      end
    end else if (com[1]) begin
      if (fast) begin
        if (at_wrap) begin
          tpw_wave = ~inv;
        end else if (match && !cmp_is_top) begin
          tpw_wave = inv;
        end
      end else begin
        if (at_top) begin
          // A compare value at TOP keeps the down-match level, so MAX stays constant.
          tpw_wave = cmp_is_top ? ~inv : inv;
        end else if (match && !down) begin
          tpw_wave = inv;
        end else if (match && down) begin
          tpw_wave = ~inv;
        end
      end
    end
  endfunction : tpw_wave

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic       fast;
  logic       pc;
  logic       tick;
  logic [7:0] top;
  logic       at_top;
  logic       at_wrap;
  logic       up_a;
  logic       up_b;
  logic       hw_ovf;
  logic       hw_fa;
  logic       hw_fb;

  always_comb begin
    next_st = st;
    fast    = tpw_is_fast(st.wgm);
    pc      = tpw_is_pc(st.wgm);
    top     = st.wgm[2] ? st.cmp_a : CNT_MAX;
    tick    = 1'b0;
    at_top  = 1'b0;
    at_wrap = 1'b0;
    up_a    = 1'b0;
    up_b    = 1'b0;
    hw_ovf  = 1'b0;
    hw_fa   = 1'b0;
    hw_fb   = 1'b0;
    next_st.rdata = RESET_BYTE;

    // Prescaler: the tick enables the counter for one clock only.
    if (st.presc_sel != PRESC_OFF) begin
      if (st.presc_cnt >= tpw_div_limit(st.presc_sel)) begin
        next_st.presc_cnt = PRESC_ZERO;
        tick              = 1'b1;
      end else begin
        next_st.presc_cnt = st.presc_cnt + PRESC_ONE;
      end
    end

    if (tick && (fast || pc)) begin
      at_top = (st.count == top);
      if (fast) begin
        at_wrap       = at_top;
        next_st.count = at_top ? CNT_BOTTOM : st.count + 8'h01;
        if (at_top) begin
          next_st.ovf = 1'b1;
          hw_ovf      = 1'b1;
          up_a        = 1'b1;
          up_b        = 1'b1;
        end
      end else begin
        if (at_top) begin
          next_st.down  = 1'b1;
          next_st.count = st.count - 8'h01;
          up_a          = 1'b1;
          up_b          = 1'b1;
        end else if (st.down) begin
          next_st.count = st.count - 8'h01;
          if (st.count == 8'h01 || st.count == CNT_BOTTOM) begin
            next_st.down  = 1'b0;
            next_st.ovf   = 1'b1;
            hw_ovf        = 1'b1;
            next_st.count = CNT_BOTTOM;
          end
        end else begin
          next_st.count = st.count + 8'h01;
        end
      end
      next_st.wave_a = tpw_wave(st.wave_a, st.com_a, fast, st.wgm[2],
                                st.count == st.cmp_a, at_top, at_wrap,
                                st.down,
                                fast ? (st.cmp_a == top) : (st.cmp_a_buf == top));
      next_st.wave_b = tpw_wave(st.wave_b, st.com_b, fast, 1'b0,
                                st.count == st.cmp_b, at_top, at_wrap,
                                st.down,
                                fast ? (st.cmp_b == top) : (st.cmp_b_buf == top));
      if (st.count == st.cmp_a) begin
        next_st.flag_a = 1'b1;
        hw_fa          = 1'b1;
      end
      if (st.count == st.cmp_b) begin
        next_st.flag_b = 1'b1;
        hw_fb          = 1'b1;
      end
    end

    if (up_a) begin
      next_st.cmp_a = st.cmp_a_buf;
    end
    if (up_b) begin
      next_st.cmp_b = st.cmp_b_buf;
    end

    // Register writes. Hardware sets win over software clears.
    if (i_wr) begin
      case (i_addr)
        ADDR_CTRL: begin
          next_st.wgm   = i_wdata[CTRL_WGM_LO +: 3];
          next_st.com_b = i_wdata[CTRL_COMB_LO +: 2];
          next_st.com_a = i_wdata[CTRL_COMA_LO +: 2];
        end
        ADDR_PRESCALE: next_st.presc_sel = i_wdata[2:0];
        ADDR_CMP_A: begin
          next_st.cmp_a_buf = i_wdata;
          if (!(fast || pc)) begin
            next_st.cmp_a = i_wdata;
          end
        end
        ADDR_CMP_B: begin
          next_st.cmp_b_buf = i_wdata;
          if (!(fast || pc)) begin
            next_st.cmp_b = i_wdata;
          end
        end
        ADDR_COUNT: next_st.count = i_wdata;
        ADDR_FLAGS: begin
          if (i_wdata[FLAG_OVF] && !hw_ovf) begin
            next_st.ovf = 1'b0;
          end
          if (i_wdata[FLAG_CMPA] && !hw_fa) begin
            next_st.flag_a = 1'b0;
          end
          if (i_wdata[FLAG_CMPB] && !hw_fb) begin
            next_st.flag_b = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        ADDR_CTRL:     next_st.rdata = {st.com_a, st.com_b, 1'b0, st.wgm};
        ADDR_PRESCALE: next_st.rdata = {5'h00, st.presc_sel};
        ADDR_CMP_A:    next_st.rdata = st.cmp_a_buf;
        ADDR_CMP_B:    next_st.rdata = st.cmp_b_buf;
        ADDR_COUNT:    next_st.rdata = st.count;
        ADDR_FLAGS:    next_st.rdata = {5'h00, st.flag_b, st.flag_a, st.ovf};
        default:       next_st.rdata = RESET_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // Override enables are registered copies so all outputs come from flops;
  // the pin direction itself stays with the port logic outside.
  logic ov_a;
  logic ov_b;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ov_a <= 1'b0;
      ov_b <= 1'b0;
    end else if (i_clk_en) begin
      ov_a <= (next_st.com_a == COM_TOGGLE) ? next_st.wgm[2] : next_st.com_a[1];
      ov_b <= next_st.com_b[1];
    end
  end

  assign o_rdata          = st.rdata;
  assign o_wave_output_a  = st.wave_a;
  assign o_wave_output_b  = st.wave_b;
  assign o_override_a     = ov_a;
  assign o_override_b     = ov_b;
  assign o_overflow_flag  = st.ovf;
  assign o_compare_flag_a = st.flag_a;
  assign o_compare_flag_b = st.flag_b;

endmodule : tpw_timer

//--- verilog/tpw_pkg.sv
// Purpose: Shared constants for the 8-bit PWM timer block.
// Assumes: One clock domain; register port with one-cycle read latency.
// Notes:   Offsets are word indices on the plain register port.
package tpw_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_PRESCALE = 4'h1;
  localparam logic [3:0] ADDR_CMP_A    = 4'h2;
  localparam logic [3:0] ADDR_CMP_B    = 4'h3;
  localparam logic [3:0] ADDR_COUNT    = 4'h4;
  localparam logic [3:0] ADDR_FLAGS    = 4'h5;
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int          CTRL_WGM_LO   = 0;
  localparam int          CTRL_COMB_LO  = 4;
  localparam int          CTRL_COMA_LO  = 6;
  localparam int          FLAG_OVF      = 0;
  localparam int          FLAG_CMPA     = 1;
  localparam int          FLAG_CMPB     = 2;
  localparam logic [2:0]  WGM_FAST_MAX  = 3'h3;
  localparam logic [2:0]  WGM_FAST_OCRA = 3'h7;
  localparam logic [2:0]  WGM_PC_MAX    = 3'h1;
  localparam logic [2:0]  WGM_PC_OCRA   = 3'h5;
  localparam logic [1:0]  COM_TOGGLE    = 2'h1;
  localparam logic [1:0]  COM_NONINV    = 2'h2;
  localparam logic [1:0]  COM_INV       = 2'h3;
  localparam logic [7:0]  CNT_BOTTOM    = 8'h00;
  localparam logic [7:0]  CNT_MAX       = 8'hff;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [2:0]  PRESC_OFF     = 3'h0;
  localparam logic [9:0]  PRESC_ZERO    = 10'h000;
  localparam logic [9:0]  PRESC_ONE     = 10'h001;
endpackage : tpw_pkg

//--- sim/tpw_timer_props.sv
// Purpose: Port-level checks for the 8-bit PWM timer block.
// Assumes: One clock domain; asynchronous active-low reset.
// Notes:   Flag rules are checked as stickiness, since set timing is a design choice.
`timescale 1ns/1ps
module tpw_timer_props
  import tpw_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_reset_n,
  input wire logic       i_clk_en,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_wave_output_a,
  input wire logic       o_wave_output_b,
  input wire logic       o_override_a,
  input wire logic       o_override_b,
  input wire logic       o_overflow_flag,
  input wire logic       o_compare_flag_a,
  input wire logic       o_compare_flag_b
);
  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  logic flag_wr;
  assign flag_wr = i_clk_en && i_wr && (i_addr == ADDR_FLAGS);
  sequence s_ovf_held;  o_overflow_flag && !(flag_wr && i_wdata[FLAG_OVF]);   endsequence
  sequence s_cmpa_held; o_compare_flag_a && !(flag_wr && i_wdata[FLAG_CMPA]); endsequence
  sequence s_cmpb_held; o_compare_flag_b && !(flag_wr && i_wdata[FLAG_CMPB]); endsequence
  sequence s_ctrl_pwm_wr; i_clk_en && i_wr && (i_addr == ADDR_CTRL) && i_wdata[0]; endsequence
  AST_OVF_STICKY: assert property (s_ovf_held |=> o_overflow_flag)
    else $error("overflow flag dropped without a clear");
  AST_CMPA_STICKY: assert property (s_cmpa_held |=> o_compare_flag_a)
    else $error("compare flag a dropped without a clear");
  AST_CMPB_STICKY: assert property (s_cmpb_held |=> o_compare_flag_b)
    else $error("compare flag b dropped without a clear");
  AST_RD_IDLE: assert property ((i_clk_en && !i_rd) |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property ((i_clk_en && i_rd && i_addr > ADDR_FLAGS) |=> o_rdata == 8'h00)
    else $error("unmapped read returned data");
  AST_OVR_A: assert property (s_ctrl_pwm_wr |=> o_override_a ==
    ($past(i_wdata[7]) || ($past(i_wdata[6]) && $past(i_wdata[2]))))
    else $error("channel a override wrong after control write");
  AST_OVR_B: assert property (s_ctrl_pwm_wr |=> o_override_b == $past(i_wdata[5]))
    else $error("channel b override wrong after control write");
  AST_FROZEN: assert property (!i_clk_en |=> $stable(o_wave_output_a) &&
    $stable(o_wave_output_b) && $stable(o_overflow_flag))
    else $error("state moved while the clock enable was low");
endmodule : tpw_timer_props
bind tpw_timer tpw_timer_props i_props (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_wave_output_a(o_wave_output_a), .o_wave_output_b(o_wave_output_b),
  .o_override_a(o_override_a), .o_override_b(o_override_b),
  .o_overflow_flag(o_overflow_flag), .o_compare_flag_a(o_compare_flag_a),
  .o_compare_flag_b(o_compare_flag_b));

//--- sim/tpw_timer_bench.sv
// Purpose: Self-checking bench for the 8-bit PWM timer block.
// Assumes: Prescale select 1 is divide by 1 and 2 is divide by 8.
// Notes:   Waveforms are judged by high time and period in clock cycles.
`timescale 1ns/1ps
module tpw_timer_bench;
  import tpw_pkg::*;
  logic       clk, i_reset_n, i_clk_en, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic       wa, wb, o_override_a, o_override_b, ovf, cfa, cfb;
  int         errors, comparisons;
  tpw_timer i_tpw_timer (.i_ref_clk(clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_wave_output_a(wa), .o_wave_output_b(wb), .o_override_a(o_override_a),
    .o_override_b(o_override_b), .o_overflow_flag(ovf), .o_compare_flag_a(cfa),
    .o_compare_flag_b(cfb));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task summarize();
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge clk);
    i_rd <= 1'b0;
    #1 chk(16'(o_rdata), 16'(e));
  endtask : rd
  // The search is bounded, so a constant output returns its level with a period of zero.
  task meas(input logic ch, output int hi, output int per);
    logic p;
    logic w;
    int   n;
    hi = 0; per = 0; n = 0;
    p = ch ? wb : wa;
    w = p;
    while (!(w && !p) && n < 3000) begin
      p = w; @(posedge clk); #1 w = ch ? wb : wa; n++;
    end
    if (n >= 3000) hi = int'(w);
    else begin
      hi = 1; per = 1; p = w; n = 0;
      forever begin
        @(posedge clk); #1 w = ch ? wb : wa;
        if ((w && !p) || n > 3000) break;
        hi += int'(w); per++; p = w; n++;
      end
    end
  endtask : meas
  task run(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b, input logic ch,
           input int eh, input int ep);
    int h;
    int p;
    wr(ADDR_CTRL, c); wr(ADDR_CMP_A, a); wr(ADDR_CMP_B, b);
    repeat (600) @(posedge clk);
    meas(ch, h, p);
    chk(16'(h), 16'(eh));
    chk(16'(p), 16'(ep));
  endtask : run
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #800000;
    errors++;
    summarize();
  end
  initial begin
    errors = 0; comparisons = 0; i_reset_n = 1'b0; i_clk_en = 1'b1;
    i_wr = 1'b0; i_rd = 1'b0; i_addr = 4'h0; i_wdata = 8'h00;
    repeat (16) @(posedge clk);
    i_reset_n <= 1'b1;
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_PRESCALE, 8'h01);
    run(8'h83, 8'h40, 8'h00, 1'b0, 65, 256);
    run(8'hc3, 8'h40, 8'h00, 1'b0, 191, 256);
    run(8'h83, 8'h00, 8'h00, 1'b0, 1, 256);
    run(8'h83, 8'hff, 8'h00, 1'b0, 1, 0);
    run(8'hc3, 8'hff, 8'h00, 1'b0, 0, 0);
    run(8'h47, 8'h00, 8'h00, 1'b0, 1, 2);
    wr(ADDR_CTRL, 8'h43);
    @(posedge clk);
    #1 chk(16'(o_override_a), 16'h0000);
    run(8'h27, 8'h3f, 8'h10, 1'b1, 17, 64);
    run(8'h81, 8'h40, 8'h00, 1'b0, 128, 510);
    run(8'hc1, 8'h40, 8'h00, 1'b0, 382, 510);
    run(8'h81, 8'h00, 8'h00, 1'b0, 0, 0);
    run(8'h81, 8'hff, 8'h00, 1'b0, 1, 0);
    run(8'h25, 8'h3f, 8'h10, 1'b1, 32, 126);
    wr(ADDR_PRESCALE, 8'h02);
    run(8'h83, 8'h40, 8'h00, 1'b0, 520, 2048);
    i_clk_en <= 1'b0;
    repeat (5) @(posedge clk);
    i_clk_en <= 1'b1;
    wr(ADDR_PRESCALE, 8'h00);
    rd(ADDR_FLAGS, 8'h07);
    wr(ADDR_FLAGS, 8'h07);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_COUNT, 8'h12);
    rd(ADDR_COUNT, 8'h12);
    rd(4'hf, 8'h00);
    rd(ADDR_CTRL, 8'h83);
    summarize();
  end
endmodule : tpw_timer_bench
